/* memory_boundary_scan_tap.sv */
// boundary-scan test access port with instruction decode and scan chains
`timescale 1ns/1ps
`include "memory_boundary_scan_tap_cfg.svh"

module memory_boundary_scan_tap
  import memory_boundary_scan_pkg::*;
#(
  parameter logic [1:0] DIE_REVISION = 2'h0,
  parameter logic [1:0] WIDTH_CODE = 2'h0,
  // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h4A5C,
  // arbitrary value
  parameter logic [10:0] MAKER_CODE = 11'h2B3
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [`BSR_LEN-1:0] ring_in_i,
  output logic [`BSR_LEN-1:0] ring_out_o,
  output logic ring_clamp_o,
  output logic ring_highz_o
);

  tap_regs_t r_r;
  tap_regs_t r_nxt;
  tdo_regs_t t_r;
  tdo_regs_t t_nxt;

  // memory clock side of the pad control crossing
  typedef struct packed {
    logic seen;
    pad_ctrl_t pads;
  } core_regs_t;

  logic [`BSR_LEN-1:0] ring_sampled;
  logic [`ID_LEN-1:0] id_word;
  pad_ctrl_t pad_tck;
  core_regs_t c_r;
  core_regs_t c_nxt;
  logic toggle_core;
  logic pad_moves;
  dr_path_t path;
  logic dr_serial_out;
  logic captures_ring;
  logic preloads_cells;

  // next controller state from the test mode select line
  function automatic tap_state_t tap_next(input tap_state_t s,
                                          input logic tms);
    tap_state_t n;
    n = s;
    case (s)
      ST_RESET:      n = tms ? ST_RESET : ST_IDLE;
      ST_IDLE:       n = tms ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_DR:  n = tms ? ST_SELECT_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  n = tms ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_IR:  n = tms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  n = tms ? ST_SELECT_DR : ST_IDLE;
      default:       n = ST_RESET;
    endcase
    return n;
  endfunction

  // which data register an instruction puts between tdi and tdo
  function automatic dr_path_t path_of(input logic [`IR_LEN-1:0] code);
    dr_path_t p;
    p = PATH_BYPASS;
    case (code)
      INSTR_EXTEST: p = PATH_BOUNDARY;
      INSTR_SAMPLE: p = PATH_BOUNDARY;
      INSTR_IDCODE: p = PATH_ID;
      INSTR_CLAMP:  p = PATH_BYPASS;
      INSTR_HIGHZ:  p = PATH_BYPASS;
      INSTR_BYPASS: p = PATH_BYPASS;
      // reserved codes fall back to the shortest path
      default:      p = PATH_BYPASS;
    endcase
    return p;
  endfunction

  // identification word assembled from its fixed fields
  always_comb begin
    id_word = '0;
    id_word[`ID_REV_MSB:`ID_REV_LSB] = {DIE_REVISION, WIDTH_CODE};
    id_word[`ID_DEV_MSB:`ID_DEV_LSB] = DEVICE_CODE;
    id_word[`ID_MAKER_MSB:`ID_MAKER_LSB] = MAKER_CODE;
    id_word[`ID_PRESENT_BIT] = `ID_PRESENT_VALUE;
  end

  // pad values come from the memory clock domain; a pad moving during
  // capture may land either way, which the scan user must tolerate
  level_sync #(
    .WIDTH(`BSR_LEN)
  ) u_ring_in_sync (
    .clk_i(tck_i),
    .reset_n_i(reset_n_i),
    .d_i(ring_in_i),
    .q_o(ring_sampled)
  );

  assign path = path_of(r_r.instr);
  assign captures_ring = (r_r.instr == INSTR_EXTEST) ||
                         (r_r.instr == INSTR_SAMPLE);
  assign preloads_cells = captures_ring;

  // serial bit presented by the selected data register
  always_comb begin
    dr_serial_out = r_r.bypass;
    case (path)
      PATH_ID:       dr_serial_out = r_r.id_shift[0];
      PATH_BOUNDARY: dr_serial_out = r_r.bsr_shift[0];
      PATH_BYPASS:   dr_serial_out = r_r.bypass;
      default:       dr_serial_out = r_r.bypass;
    endcase
  end

  // rising test clock: controller, instruction and data registers
  always_comb begin
    r_nxt = r_r;
    r_nxt.state = tap_next(r_r.state, tms_i);
    case (r_r.state)
      ST_RESET: begin
        r_nxt.instr = `IR_RESET_CODE;
        r_nxt.clamp = 1'b0;
        r_nxt.highz = 1'b0;
      end
      ST_CAPTURE_IR: begin
        r_nxt.ir_shift = `IR_CAPTURE_VALUE;
      end
      ST_SHIFT_IR: begin
        r_nxt.ir_shift = {tdi_i, r_r.ir_shift[`IR_LEN-1:1]};
      end
      ST_UPDATE_IR: begin
        // new instruction takes hold only here
        r_nxt.instr = r_r.ir_shift;
        r_nxt.clamp = (r_r.ir_shift == INSTR_CLAMP);
        r_nxt.highz = (r_r.ir_shift == INSTR_HIGHZ);
      end
      ST_CAPTURE_DR: begin
        r_nxt.bypass = `BYPASS_CAPTURE_VALUE;
        if (path == PATH_ID) begin
          r_nxt.id_shift = id_word;
        end
        if (captures_ring) begin
          r_nxt.bsr_shift = ring_sampled;
        end
      end
      ST_SHIFT_DR: begin
        case (path)
          PATH_ID: begin
            r_nxt.id_shift = {tdi_i, r_r.id_shift[`ID_LEN-1:1]};
          end
          PATH_BOUNDARY: begin
            // cell one sits at index zero and leaves first
            r_nxt.bsr_shift = {tdi_i, r_r.bsr_shift[`BSR_LEN-1:1]};
          end
          default: begin
            r_nxt.bypass = tdi_i;
          end
        endcase
      end
      ST_UPDATE_DR: begin
        // preload lets clamp drive known values later
        if (preloads_cells) begin
          r_nxt.bsr_hold = r_r.bsr_shift;
        end
      end
      default: begin
        r_nxt.ir_shift = r_r.ir_shift;
      end
    endcase
    // test-logic-reset takes hold on entry, so five high tms edges
    // always leave the reset instruction and free pads behind
    if (r_nxt.state == ST_RESET) begin
      r_nxt.instr = `IR_RESET_CODE;
      r_nxt.clamp = 1'b0;
      r_nxt.highz = 1'b0;
    end
    // any change of the pad word is announced by one toggle
    pad_moves = (r_nxt.bsr_hold != r_r.bsr_hold) ||
                (r_nxt.clamp != r_r.clamp) ||
                (r_nxt.highz != r_r.highz);
    if (pad_moves) begin
      r_nxt.pad_toggle = ~r_r.pad_toggle;
    end
  end

  always_ff @(posedge tck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r.state <= ST_RESET;
      r_r.ir_shift <= '0;
      r_r.instr <= `IR_RESET_CODE;
      r_r.bypass <= 1'b0;
      r_r.id_shift <= '0;
      r_r.bsr_shift <= '0;
      r_r.bsr_hold <= '0;
      r_r.clamp <= 1'b0;
      r_r.highz <= 1'b0;
      r_r.pad_toggle <= 1'b0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // falling test clock: output bit and its enable
  always_comb begin
    t_nxt = t_r;
    t_nxt.tdo_oe = 1'b0;
    t_nxt.tdo = 1'b0;
    if (r_r.state == ST_SHIFT_IR) begin
      t_nxt.tdo_oe = 1'b1;
      t_nxt.tdo = r_r.ir_shift[0];
    end else if (r_r.state == ST_SHIFT_DR) begin
      t_nxt.tdo_oe = 1'b1;
      t_nxt.tdo = dr_serial_out;
    end
  end

  always_ff @(negedge tck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign tdo_o = t_r.tdo;
  assign tdo_oe_o = t_r.tdo_oe;

  // only clamp and highz raise pad flags; extest and sample still load the
  // cell word at update-dr, and bsr_hold then reaches ring_out_o as it is
  always_comb begin
    pad_tck.cells = r_r.bsr_hold;
    pad_tck.clamp = r_r.clamp;
    pad_tck.highz = r_r.highz;
  end

  // only the toggle crosses on flops; the pad word is taken whole once
  // the toggle has settled, so all pads see one consistent update; the
  // cost is that the word must hold still for three memory clocks
  level_sync #(
    .WIDTH(1)
  ) u_toggle_sync (
    .clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .d_i(r_r.pad_toggle),
    .q_o(toggle_core)
  );

  always_comb begin
    c_nxt = c_r;
    c_nxt.seen = toggle_core;
    if (toggle_core != c_r.seen) begin
      c_nxt.pads = pad_tck;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c_r.seen <= 1'b0;
      c_r.pads.cells <= '0;
      c_r.pads.clamp <= 1'b0;
      c_r.pads.highz <= 1'b0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign ring_out_o = c_r.pads.cells;
  assign ring_clamp_o = c_r.pads.clamp;
  assign ring_highz_o = c_r.pads.highz;

endmodule

/* memory_boundary_scan_tap_cfg.svh */
// constants for the boundary-scan test access port
`ifndef MEMORY_BOUNDARY_SCAN_TAP_CFG_SVH
`define MEMORY_BOUNDARY_SCAN_TAP_CFG_SVH

// register lengths
`define IR_LEN 8
`define ID_LEN 32
`define BSR_LEN 113

// instruction codes
`define CODE_EXTEST 8'h00
`define CODE_IDCODE 8'h21
`define CODE_SAMPLE 8'h05
`define CODE_CLAMP 8'h07
`define CODE_HIGHZ 8'h03
`define CODE_BYPASS 8'hFF

// reset and capture values
`define IR_RESET_CODE `CODE_IDCODE
`define IR_CAPTURE_VALUE 8'h01
`define BYPASS_CAPTURE_VALUE 1'h0

// identification word field positions
`define ID_REV_MSB 31
`define ID_REV_LSB 28
`define ID_DEV_MSB 27
`define ID_DEV_LSB 12
`define ID_MAKER_MSB 11
`define ID_MAKER_LSB 1
`define ID_PRESENT_BIT 0
`define ID_PRESENT_VALUE 1'h1

`endif

/* memory_boundary_scan_pkg.sv */
// types shared by the boundary-scan test access port
`include "memory_boundary_scan_tap_cfg.svh"

package memory_boundary_scan_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SELECT_DR,
    ST_CAPTURE_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPDATE_DR,
    ST_SELECT_IR,
    ST_CAPTURE_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPDATE_IR
  } tap_state_t;

  typedef enum logic [7:0] {
    INSTR_EXTEST = `CODE_EXTEST,
    INSTR_IDCODE = `CODE_IDCODE,
    INSTR_SAMPLE = `CODE_SAMPLE,
    INSTR_CLAMP = `CODE_CLAMP,
    INSTR_HIGHZ = `CODE_HIGHZ,
    INSTR_BYPASS = `CODE_BYPASS
  } instr_t;

  typedef enum logic [1:0] {
    PATH_BYPASS,
    PATH_ID,
    PATH_BOUNDARY
  } dr_path_t;

  typedef struct packed {
    tap_state_t state;
    logic [`IR_LEN-1:0] ir_shift;
    logic [`IR_LEN-1:0] instr;
    logic bypass;
    logic [`ID_LEN-1:0] id_shift;
    logic [`BSR_LEN-1:0] bsr_shift;
    logic [`BSR_LEN-1:0] bsr_hold;
    logic clamp;
    logic highz;
    logic pad_toggle;
  } tap_regs_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } tdo_regs_t;

  // what the pad ring needs from the scan logic
  typedef struct packed {
    logic [`BSR_LEN-1:0] cells;
    logic clamp;
    logic highz;
  } pad_ctrl_t;

endpackage

/* level_sync.sv */
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps

module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_regs_t;

  sync_regs_t r_r;
  sync_regs_t r_nxt;

  // the first stage feeds only the second stage
  always_comb begin
    r_nxt = r_r;
    r_nxt.meta = d_i;
    r_nxt.stable = r_r.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q_o = r_r.stable;

endmodule

/* tap_port_asserts.sv */
// port assertions for the boundary-scan test access port
`timescale 1ns/1ps
`include "memory_boundary_scan_tap_cfg.svh"
module tap_port_asserts (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic [`BSR_LEN-1:0] ring_in_i,
  input wire logic [`BSR_LEN-1:0] ring_out_o,
  input wire logic ring_clamp_o,
  input wire logic ring_highz_o
);
  sequence leave_shift;
    tms_i ##1 tms_i;
  endsequence
  AST_OE_DROP: assert property (@(posedge tck_i)
    disable iff (!reset_n_i) leave_shift |-> !tdo_oe_o)
    else $error("tdo enable late");
  AST_OE_ENTRY: assert property (@(posedge tck_i)
    disable iff (!reset_n_i) $rose(tdo_oe_o) |-> !$past(tms_i))
    else $error("tdo enable early");
  AST_TDO_QUIET: assert property (@(negedge tck_i)
    disable iff (!reset_n_i) !tdo_oe_o |-> !tdo_o)
    else $error("tdo not quiet");
  // tdo may only move on the falling test clock edge
  AST_TDO_FALL: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) tck_i && $past(tck_i) |-> $stable(tdo_o))
    else $error("tdo moved high");
  AST_PAD_EXCL: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) !(ring_clamp_o && ring_highz_o))
    else $error("clamp with highz");
  AST_CLAMP_CELLS: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) $rose(ring_clamp_o) |-> $stable(ring_out_o))
    else $error("clamp moved cells");
  AST_HIGHZ_CELLS: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) $rose(ring_highz_o) |-> $stable(ring_out_o))
    else $error("highz moved cells");
  AST_RESET_CLEAN: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) $rose(reset_n_i) |->
    !ring_clamp_o && !ring_highz_o && ring_out_o == 113'h0)
    else $error("pads not clean");
endmodule
bind memory_boundary_scan_tap tap_port_asserts chk (.core_clk_i,
  .reset_n_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .ring_in_i,
  .ring_out_o, .ring_clamp_o, .ring_highz_o);

/* scan_controller_model.sv */
// board-level scan controller model driving the test port
`timescale 1ns/1ps
module scan_controller_model (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // clock stands still between frames
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end
  // one test clock; tdo is taken at the rising edge
  task automatic pulse(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #32;
    tck_o = 1'h1;
    tdo = tdo_i;
    #32;
    tck_o = 1'h0;
  endtask
  task automatic to_idle();
    logic t;
    repeat (5) pulse(1'h1, 1'h0, t);
    pulse(1'h0, 1'h0, t);
  endtask
  // idle to shift, len bits lsb first, back to idle
  task automatic scan(input logic ir, input int len,
    input logic [112:0] din, output logic [112:0] dout);
    logic t;
    dout = 113'h0;
    pulse(1'h1, 1'h0, t);
    if (ir) pulse(1'h1, 1'h0, t);
    pulse(1'h0, 1'h0, t);
    pulse(1'h0, 1'h0, t);
    // any code is sent; only scenarios ask for reserved ones
    for (int i = 0; i < len; i++) begin
      pulse(i == len - 1, din[i], t);
      dout[i] = t;
    end
    pulse(1'h1, 1'h0, t);
    pulse(1'h0, 1'h0, t);
  endtask
endmodule

/* memory_boundary_scan_tap_tb.sv */
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`include "memory_boundary_scan_tap_cfg.svh"
module memory_boundary_scan_tap_tb
  import memory_boundary_scan_pkg::*;
;
  localparam logic [31:0] ID_EXP = {2'h1, 2'h2, 16'hC3A5, 11'h5D6, 1'h1};
  localparam logic [112:0] PAT_A = {1'h1, {14{8'hA7}}};
  localparam logic [112:0] PAT_B = {1'h0, {14{8'h1E}}};
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic tck, tms, tdi, tdo, tdo_oe, clamp, highz;
  logic [112:0] ring_in = 113'h0;
  logic [112:0] ring_out;
  logic [112:0] dout;
  int err_total = 0;
  int checks = 0;
  // identity parameters below are arbitrary values
  memory_boundary_scan_tap #(.DIE_REVISION(2'h1), .WIDTH_CODE(2'h2),
    .DEVICE_CODE(16'hC3A5), .MAKER_CODE(11'h5D6)) DUT (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ring_in_i(ring_in),
    .ring_out_o(ring_out), .ring_clamp_o(clamp), .ring_highz_o(highz));
  scan_controller_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic check(input logic [112:0] seen, input logic [112:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // pad flags cross into the core domain within three core clocks
  task automatic load_ir(input logic [7:0] code);
    ctl.scan(1'h1, `IR_LEN, {105'h0, code}, dout);
    check(dout[7:0], 8'h01);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_idcode();
    ctl.scan(1'h0, `ID_LEN, 113'h0, dout);
    check(dout[31:0], ID_EXP);
    check({clamp, highz}, 2'h0);
    check({tdo_oe, tdo}, 2'h0);
  endtask
  task automatic t_capture(input logic [7:0] code, input logic [112:0] pat);
    @(posedge core_clk) ring_in <= pat;
    load_ir(code);
    ctl.scan(1'h0, `BSR_LEN, ~pat, dout);
    check(dout, pat);
    repeat (4) @(posedge core_clk);
    check(ring_out, ~pat);
    check({clamp, highz}, 2'h0);
  endtask
  task automatic t_one_bit();
    logic [7:0] codes [5] = '{INSTR_BYPASS, INSTR_CLAMP, INSTR_HIGHZ,
      8'h5A, 8'h42};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      ctl.scan(1'h0, 2, 113'h1, dout);
      check(dout[1:0], 2'h2);
      check({clamp, highz}, {codes[i] == 8'h07, codes[i] == 8'h03});
      check(ring_out, ~PAT_B);
    end
  endtask
  // stored cells survive a tms reset, the clamp does not
  task automatic t_tms_reset();
    load_ir(INSTR_CLAMP);
    check(clamp, 1'h1);
    ctl.to_idle();
    repeat (4) @(posedge core_clk);
    check(clamp, 1'h0);
    check(ring_out, ~PAT_B);
    t_idcode();
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'h1;
    ctl.to_idle();
    t_idcode();
    t_capture(INSTR_EXTEST, PAT_A);
    t_capture(INSTR_SAMPLE, PAT_B);
    t_one_bit();
    t_tms_reset();
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule
